// ===== uart_pkg.sv
package uart_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADR_W = 22;              // Byte address width
    localparam int IDX_W = ADR_W - 2;       // Word index width

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_GATE_BANK = 20'h8721B;
    localparam logic [IDX_W-1:0] IDX_PRIORITY = 20'h87382;
    localparam logic [IDX_W-1:0] IDX_FORMAT = 20'h88250;
    localparam logic [IDX_W-1:0] IDX_DIVISOR = 20'h88251;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 20'h88252;
    localparam logic [IDX_W-1:0] IDX_TX_BYTE = 20'h88253;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 20'h88254;
    localparam logic [IDX_W-1:0] IDX_RX_BYTE = 20'h88255;
    localparam logic [IDX_W-1:0] IDX_CARD_MODE = 20'h88256;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_TX_DONE_IE = 2;
    localparam int CTL_RX_ON = 4;
    localparam int CTL_TX_ON = 5;
    localparam int CTL_RX_IE = 6;
    localparam int CTL_TX_IE = 7;
    localparam int FLG_TX_DONE = 2;
    localparam int FLG_FRAMING = 4;
    localparam int FLG_OVERRUN = 5;
    localparam int FLG_RX_FULL = 6;
    localparam int FLG_TX_EMPTY = 7;
    localparam int GATE_RX_FULL = 7;

    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_MASK = 8'hF7;
    localparam logic [7:0] FMT_MASK = 8'hEF;
    localparam logic [7:0] CARD_MASK = 8'h09;
    localparam logic [7:0] PRIO_MASK = 8'h0F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DIVISOR_RST = 8'hFF;
    localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    localparam int OVERSAMPLE = 16;         // Ticks per bit
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // Register select codes and machine states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0, SEL_GATE = 4'h1, SEL_PRIO = 4'h2,
        SEL_FMT = 4'h3, SEL_DIV = 4'h4, SEL_CTL = 4'h5,
        SEL_TXB = 4'h6, SEL_FLG = 4'h7, SEL_RXB = 4'h8,
        SEL_CARD = 4'h9
    } reg_sel_t;

    typedef enum logic [1:0] {
        FR_IDLE = 2'h0, FR_START = 2'h1, FR_DATA = 2'h2, FR_STOP = 2'h3
    } frame_st_t;

endpackage : uart_pkg

// ===== bit_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
module bit_rate_gen
    import uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [7:0] divisor_i,
    input wire logic [1:0] prescale_i,
    output logic tick_o
);

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } gen_st_t;

    gen_st_t cur_r;
    gen_st_t cur_nxt;
    logic [15:0] period;

    // ------------------------------------------------------------
    // Tick every 2*(N+1)*4^n clocks; 16 ticks make one bit
    // ------------------------------------------------------------
    assign period = (16'(divisor_i) + 16'h0001) << {prescale_i, 1'b1};

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.tick = 1'b0;
        if (!run_i)
        begin
            cur_nxt.cnt = 16'h0000; // Restart phase on every enable
        end
        else if (cur_r.cnt >= period - 16'h0001)
        begin
            cur_nxt.cnt = 16'h0000;
            cur_nxt.tick = 1'b1;
        end
        else
        begin
            cur_nxt.cnt = cur_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur_r <= '0;
        else
            cur_r <= cur_nxt;
    end

    assign tick_o = cur_r.tick;

endmodule : bit_rate_gen
`default_nettype wire

// ===== async_serial_port_8n1.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_8n1
    import uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic tx_empty_irq_o,
    output logic tx_done_irq_o,
    output logic rx_full_irq_o,
    output logic rx_error_irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] fmt;
        logic [7:0] div;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic [7:0] card;
        logic [7:0] gate;
        logic [7:0] prio;
        logic tx_empty;
        logic rx_full;
        logic framing_err_flag;
        logic overrun_flag;
        frame_st_t tx_st;
        logic [3:0] tx_tk;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic txd;
        frame_st_t rx_st;
        logic [3:0] rx_tk;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic ack;
        logic [31:0] dat;
    } port_st_t;

    port_st_t cur_r;
    port_st_t cur_nxt;
    logic tick;
    logic tx_on;
    logic rx_on;
    logic locked;
    logic tx_done;
    logic level_on;
    logic req;
    reg_sel_t rsel;

    // ------------------------------------------------------------
    // Register decode, shared by read and write paths
    // ------------------------------------------------------------
    function automatic reg_sel_t decode(input logic [IDX_W-1:0] idx);
        reg_sel_t s;
        s = SEL_NONE;
        unique case (idx)
            IDX_GATE_BANK: s = SEL_GATE;
            IDX_PRIORITY: s = SEL_PRIO;
            IDX_FORMAT: s = SEL_FMT;
            IDX_DIVISOR: s = SEL_DIV;
            IDX_CONTROL: s = SEL_CTL;
            IDX_TX_BYTE: s = SEL_TXB;
            IDX_FLAGS: s = SEL_FLG;
            IDX_RX_BYTE: s = SEL_RXB;
            IDX_CARD_MODE: s = SEL_CARD;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    // ------------------------------------------------------------
    // Derived levels
    // ------------------------------------------------------------
    assign tx_on = cur_r.ctl[CTL_TX_ON];
    assign rx_on = cur_r.ctl[CTL_RX_ON];
    assign locked = tx_on | rx_on;
    assign tx_done = (cur_r.tx_st == FR_IDLE) & cur_r.tx_empty;
    assign level_on = (cur_r.prio[3:0] != 4'h0);
    assign req = cyc_i & stb_i;
    assign rsel = decode(adr_i);

    // Only the internal source exists; other clock sources stall
    // the generator rather than guessing at an external pin.
    bit_rate_gen u_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(locked & (cur_r.ctl[1:0] == CLK_SRC_INTERNAL)),
        .divisor_i(cur_r.div),
        .prescale_i(cur_r.fmt[1:0]),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        cur_nxt = cur_r;

        // Input synchroniser, then edge history
        cur_nxt.rx_s1 = rxd_i;
        cur_nxt.rx_s2 = cur_r.rx_s1;
        cur_nxt.rx_prev = cur_r.rx_s2;

        // Bus: answer one cycle after the request, for one cycle
        cur_nxt.ack = req & ~cur_r.ack;
        if (req && !cur_r.ack)
        begin
            cur_nxt.dat = 32'h0000_0000;
            unique case (rsel)
                SEL_GATE: cur_nxt.dat[7:0] = cur_r.gate;
                SEL_PRIO: cur_nxt.dat[7:0] = cur_r.prio;
                SEL_FMT: cur_nxt.dat[7:0] = cur_r.fmt;
                SEL_DIV: cur_nxt.dat[7:0] = cur_r.div;
                SEL_CTL: cur_nxt.dat[7:0] = cur_r.ctl;
                SEL_TXB: cur_nxt.dat[7:0] = cur_r.tx_byte;
                SEL_FLG:
                begin
                    cur_nxt.dat[FLG_TX_EMPTY] = cur_r.tx_empty;
                    cur_nxt.dat[FLG_RX_FULL] = cur_r.rx_full;
                    cur_nxt.dat[FLG_OVERRUN] = cur_r.overrun_flag;
                    cur_nxt.dat[FLG_FRAMING] = cur_r.framing_err_flag;
                    cur_nxt.dat[FLG_TX_DONE] = tx_done;
                end
                SEL_RXB: cur_nxt.dat[7:0] = cur_r.rx_byte;
                SEL_CARD: cur_nxt.dat[7:0] = cur_r.card;
                SEL_NONE: cur_nxt.dat = 32'h0000_0000;
            endcase
        end

        // Writes and read side effects land on the acknowledged edge
        if (req && cur_r.ack && we_i && sel_i[0])
        begin
            unique case (rsel)
                SEL_GATE: cur_nxt.gate = dat_i[7:0];
                SEL_PRIO: cur_nxt.prio = dat_i[7:0] & PRIO_MASK;
                SEL_FMT:
                begin
                    // Format fields frozen while the link runs
                    if (!locked)
                        cur_nxt.fmt = dat_i[7:0] & FMT_MASK;
                end
                SEL_DIV:
                begin
                    if (!locked)
                        cur_nxt.div = dat_i[7:0];
                end
                SEL_CTL:
                begin
                    if (!locked)
                    begin
                        cur_nxt.ctl = dat_i[7:0] & CTL_MASK;
                    end
                    else
                    begin
                        // TX/RX enables may only drop; source stays put
                        cur_nxt.ctl[7:6] = dat_i[7:6];
                        cur_nxt.ctl[5:4] = cur_r.ctl[5:4]
                            & dat_i[5:4];
                        cur_nxt.ctl[CTL_TX_DONE_IE] =
                            dat_i[CTL_TX_DONE_IE];
                        cur_nxt.ctl[1:0] = cur_r.ctl[1:0];
                    end
                end
                SEL_TXB:
                begin
                    cur_nxt.tx_byte = dat_i[7:0];
                    cur_nxt.tx_empty = 1'b0;
                end
                SEL_FLG:
                begin
                    // Writing 1 leaves a flag as it stands
                    if (!dat_i[FLG_FRAMING])
                        cur_nxt.framing_err_flag = 1'b0;
                    if (!dat_i[FLG_OVERRUN])
                        cur_nxt.overrun_flag = 1'b0;
                end
                SEL_RXB: cur_nxt.rx_byte = dat_i[7:0];
                SEL_CARD:
                begin
                    if (!locked)
                        cur_nxt.card = dat_i[7:0] & CARD_MASK;
                end
                SEL_NONE: cur_nxt.gate = cur_r.gate;
            endcase
        end
        if (req && cur_r.ack && !we_i && rsel == SEL_RXB)
            cur_nxt.rx_full = 1'b0; // Read releases the buffer

        // Transmitter: fixed 8N1, LSB first, 16 ticks per bit
        // Multiprocessor, parity, length, order fields are held
        // but only their zero settings are acted on.
        unique case (cur_r.tx_st)
            FR_IDLE:
            begin
                cur_nxt.txd = 1'b1;
                if (tx_on && !cur_r.tx_empty && tick)
                begin
                    cur_nxt.tx_sh = cur_r.tx_byte;
                    cur_nxt.tx_empty = 1'b1;
                    cur_nxt.tx_tk = 4'h0;
                    cur_nxt.txd = 1'b0;
                    cur_nxt.tx_st = FR_START;
                end
            end
            FR_START:
            begin
                if (tick)
                begin
                    cur_nxt.tx_tk = cur_r.tx_tk + 4'h1;
                    if (cur_r.tx_tk == TICK_LAST)
                    begin
                        cur_nxt.txd = cur_r.tx_sh[0];
                        cur_nxt.tx_sh = {1'b0, cur_r.tx_sh[7:1]};
                        cur_nxt.tx_bit = 3'h0;
                        cur_nxt.tx_st = FR_DATA;
                    end
                end
            end
            FR_DATA:
            begin
                if (tick)
                begin
                    cur_nxt.tx_tk = cur_r.tx_tk + 4'h1;
                    if (cur_r.tx_tk == TICK_LAST)
                    begin
                        if (cur_r.tx_bit == BIT_LAST)
                        begin
                            cur_nxt.txd = 1'b1;
                            cur_nxt.tx_st = FR_STOP;
                        end
                        else
                        begin
                            cur_nxt.txd = cur_r.tx_sh[0];
                            cur_nxt.tx_sh = {1'b0, cur_r.tx_sh[7:1]};
                            cur_nxt.tx_bit = cur_r.tx_bit + 3'h1;
                        end
                    end
                end
            end
            FR_STOP:
            begin
                if (tick)
                begin
                    cur_nxt.tx_tk = cur_r.tx_tk + 4'h1;
                    if (cur_r.tx_tk == TICK_LAST)
                        cur_nxt.tx_st = FR_IDLE;
                end
            end
        endcase
        if (!tx_on)
        begin
            // Dropping the enable aborts and idles the line
            cur_nxt.tx_st = FR_IDLE;
            cur_nxt.txd = 1'b1;
        end

        // Receiver: falling edge starts, mid-bit sampling
        unique case (cur_r.rx_st)
            FR_IDLE:
            begin
                if (cur_r.rx_prev && !cur_r.rx_s2)
                begin
                    cur_nxt.rx_tk = 4'h0;
                    cur_nxt.rx_st = FR_START;
                end
            end
            FR_START:
            begin
                if (tick)
                begin
                    cur_nxt.rx_tk = cur_r.rx_tk + 4'h1;
                    if (cur_r.rx_tk == TICK_MID)
                    begin
                        // A glitch shorter than half a bit is dropped
                        cur_nxt.rx_tk = 4'h0;
                        cur_nxt.rx_bit = 3'h0;
                        cur_nxt.rx_st = cur_r.rx_s2 ? FR_IDLE : FR_DATA;
                    end
                end
            end
            FR_DATA:
            begin
                if (tick)
                begin
                    cur_nxt.rx_tk = cur_r.rx_tk + 4'h1;
                    if (cur_r.rx_tk == TICK_LAST)
                    begin
                        cur_nxt.rx_sh = {cur_r.rx_s2,
                            cur_r.rx_sh[7:1]};
                        cur_nxt.rx_bit = cur_r.rx_bit + 3'h1;
                        if (cur_r.rx_bit == BIT_LAST)
                            cur_nxt.rx_st = FR_STOP;
                    end
                end
            end
            FR_STOP:
            begin
                if (tick)
                begin
                    cur_nxt.rx_tk = cur_r.rx_tk + 4'h1;
                    if (cur_r.rx_tk == TICK_LAST)
                    begin
                        cur_nxt.rx_st = FR_IDLE;
                        // Flag sets come after bus clears: set wins
                        if (!cur_r.rx_s2)
                            cur_nxt.framing_err_flag = 1'b1;
                        else if (cur_r.rx_full)
                            cur_nxt.overrun_flag = 1'b1;
                        else
                        begin
                            cur_nxt.rx_byte = cur_r.rx_sh;
                            cur_nxt.rx_full = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (!rx_on)
            cur_nxt.rx_st = FR_IDLE;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur_r <= '0;
            cur_r.div <= DIVISOR_RST;
            cur_r.ctl <= REG_RST;
            cur_r.tx_empty <= 1'b1;
            cur_r.txd <= 1'b1;
            cur_r.rx_s1 <= 1'b1;
            cur_r.rx_s2 <= 1'b1;
            cur_r.rx_prev <= 1'b1;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs and request levels
    // ------------------------------------------------------------
    assign dat_o = cur_r.dat;
    assign ack_o = cur_r.ack;
    assign txd_o = cur_r.txd;
    assign tx_empty_irq_o = level_on & tx_on & cur_r.tx_empty
        & cur_r.ctl[CTL_TX_IE];
    assign tx_done_irq_o = level_on & tx_on & tx_done
        & cur_r.ctl[CTL_TX_DONE_IE];
    assign rx_full_irq_o = level_on & cur_r.rx_full
        & cur_r.gate[GATE_RX_FULL] & cur_r.ctl[CTL_RX_IE];
    assign rx_error_irq_o = level_on & (cur_r.framing_err_flag | cur_r.overrun_flag)
        & cur_r.ctl[CTL_RX_IE];

endmodule : async_serial_port_8n1
`default_nettype wire

// ===== uart_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uart_port_checker
    import uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic txd_o,
    input wire logic tx_empty_irq_o,
    input wire logic tx_done_irq_o,
    input wire logic rx_full_irq_o,
    input wire logic rx_error_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Shadow of the enable bits that are never locked
    // ------------------------------------------------------------
    logic [7:0] ctl_r;
    logic [3:0] prio_r;
    logic wr_ack;
    assign wr_ack = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    // Updated on the ack edge, like the real registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctl_r <= 8'h00;
            prio_r <= 4'h0;
        end
        else if (wr_ack && adr_i == IDX_CONTROL)
            ctl_r <= dat_i[7:0];
        else if (wr_ack && adr_i == IDX_PRIORITY)
            prio_r <= dat_i[3:0];
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_start;
        $fell(txd_o);
    endsequence
    property p_ack_next; s_take |=> ack_o; endproperty
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_reset_quiet;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && txd_o && dat_o == 32'h0;
    endproperty
    property p_prio_gate;
        prio_r == 4'h0 |-> !(tx_empty_irq_o || tx_done_irq_o ||
            rx_full_irq_o || rx_error_irq_o);
    endproperty
    property p_tx_empty_gate; !ctl_r[CTL_TX_IE] |-> !tx_empty_irq_o;
    endproperty
    property p_rx_gate;
        !ctl_r[CTL_RX_IE] |-> !rx_full_irq_o && !rx_error_irq_o;
    endproperty
    property p_tx_done_gate; !ctl_r[CTL_TX_DONE_IE] |-> !tx_done_irq_o;
    endproperty
    // A start bit spans at least eight clocks at any divisor
    property p_start_low; s_start |-> !txd_o [*8]; endproperty
    property p_upper_zero; ack_o |-> dat_o[31:8] == 24'h0; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset");
    a_prio_gate: assert property (p_prio_gate) else $error("lvl0");
    a_tx_empty_gate: assert property (p_tx_empty_gate)
        else $error("tx empty irq");
    a_rx_gate: assert property (p_rx_gate) else $error("rx irq");
    a_tx_done_gate: assert property (p_tx_done_gate)
        else $error("tx done irq");
    a_start_low: assert property (p_start_low) else $error("start");
    a_upper_zero: assert property (p_upper_zero) else $error("dat");
endmodule : uart_port_checker
bind async_serial_port_8n1 uart_port_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o),
    .tx_empty_irq_o(tx_empty_irq_o), .tx_done_irq_o(tx_done_irq_o),
    .rx_full_irq_o(rx_full_irq_o), .rx_error_irq_o(rx_error_irq_o)
);
`default_nettype wire

// ===== serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int BIT_CLKS = 32)
(
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic [7:0] got_o,
    output logic [7:0] got_n_o
);
    // ------------------------------------------------------------
    // Sender: idle high line, frame timed in whole clocks
    // ------------------------------------------------------------
    initial line_o = 1'b1;
    task automatic send(input logic [7:0] b, input logic stop_ok);
        logic [9:0] fr;
        fr = {stop_ok, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            line_o <= fr[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask : send
    // ------------------------------------------------------------
    // Receiver: mid-bit sampling; bad stop is not counted
    // ------------------------------------------------------------
    initial
    begin
        got_o = 8'h00;
        got_n_o = 8'h00;
        forever
        begin
            @(negedge line_i);
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk_i);
                got_o[i] = line_i;
            end
            repeat (BIT_CLKS) @(posedge clk_i);
            if (line_i === 1'b1)
                got_n_o = got_n_o + 8'h01;
        end
    end
endmodule : serial_peer
`default_nettype wire

// ===== async_serial_port_8n1_bench.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_8n1_bench;
    import uart_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rxd_i, txd_o;
    logic tx_empty_irq_o, tx_done_irq_o, rx_full_irq_o, rx_error_irq_o;
    logic [ADR_W-1:2] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [7:0] got_o, got_n_o, q;
    int fail_count = 0, tests_run = 0, cycles = 0, n;
    typedef struct packed {logic [19:0] a; logic [7:0] w, r;} row_t;
    row_t rows [11] = '{'{IDX_FORMAT, 8'hFF, 8'hEF},
        '{IDX_FORMAT, 8'h00, 8'h00}, '{IDX_CARD_MODE, 8'hFF, 8'h09},
        '{IDX_CARD_MODE, 8'h00, 8'h00}, '{IDX_CONTROL, 8'h03, 8'h03},
        '{IDX_CONTROL, 8'h00, 8'h00}, '{IDX_PRIORITY, 8'hFF, 8'h0F},
        '{IDX_DIVISOR, 8'h00, 8'h00}, '{IDX_GATE_BANK, 8'h80, 8'h80},
        '{20'h00010, 8'h5A, 8'h00}, '{IDX_FLAGS, 8'hFF, 8'h84}};
    async_serial_port_8n1 dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rxd_i(rxd_i), .txd_o(txd_o), .tx_empty_irq_o(tx_empty_irq_o),
        .tx_done_irq_o(tx_done_irq_o), .rx_full_irq_o(rx_full_irq_o),
        .rx_error_irq_o(rx_error_irq_o));
    serial_peer #(.BIT_CLKS(32)) peer_u (.clk_i(clk_i), .line_i(txd_o),
        .line_o(rxd_i), .got_o(got_o), .got_n_o(got_n_o));
    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle; holds until ack is sampled high
    task automatic wb(input logic wr, input logic [19:0] a,
        input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 4'h1;
        we_i <= wr;
        adr_i <= a;
        dat_i <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        if (n >= 50)
            check(8'h00, 8'h01);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        check(q, exp);
    endtask : rd
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        sel_i = 4'h1;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            wb(1'b1, rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        // Second reset in mid-run restores defaults
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_DIVISOR, DIVISOR_RST);
        rd(IDX_FLAGS, 8'h84);
        wb(1'b1, IDX_DIVISOR, 8'h00);
        repeat (32) @(posedge clk_i);
        wb(1'b1, IDX_PRIORITY, 8'h01);
        wb(1'b1, IDX_GATE_BANK, 8'h80);
        // Transmit with the locks engaged mid-frame
        wb(1'b1, IDX_CONTROL, 8'hA4);
        check({7'h0, tx_empty_irq_o}, 8'h01);
        check({7'h0, tx_done_irq_o}, 8'h01);
        wb(1'b1, IDX_TX_BYTE, 8'hA5);
        repeat (16) @(posedge clk_i);
        rd(IDX_FLAGS, 8'h80);
        check({7'h0, tx_done_irq_o}, 8'h00);
        wb(1'b1, IDX_DIVISOR, 8'h55);
        rd(IDX_DIVISOR, 8'h00);
        wb(1'b1, IDX_CONTROL, 8'hB7);
        rd(IDX_CONTROL, 8'hA4);
        wb(1'b1, IDX_FORMAT, 8'h80);
        rd(IDX_FORMAT, 8'h00);
        n = 0;
        while (got_n_o !== 8'h01 && n < 1000)
        begin
            @(posedge clk_i);
            n++;
        end
        check(got_o, 8'hA5);
        check(got_n_o, 8'h01);
        repeat (32) @(posedge clk_i);
        rd(IDX_FLAGS, 8'h84);
        wb(1'b1, IDX_CONTROL, 8'h00);
        check({7'h0, tx_empty_irq_o}, 8'h00);
        // Receive, overrun, flag clearing, framing, disabled receiver
        wb(1'b1, IDX_CONTROL, 8'h50);
        peer_u.send(8'h3C, 1'b1);
        check({7'h0, rx_full_irq_o}, 8'h01);
        rd(IDX_RX_BYTE, 8'h3C);
        peer_u.send(8'h11, 1'b1);
        peer_u.send(8'h22, 1'b1);
        rd(IDX_FLAGS, 8'hE4);
        check({7'h0, rx_error_irq_o}, 8'h01);
        wb(1'b1, IDX_FLAGS, 8'hFF);
        rd(IDX_FLAGS, 8'hE4);
        wb(1'b1, IDX_FLAGS, 8'h00);
        rd(IDX_FLAGS, 8'hC4);
        rd(IDX_RX_BYTE, 8'h11);
        peer_u.send(8'h77, 1'b0);
        rd(IDX_FLAGS, 8'h94);
        wb(1'b1, IDX_FLAGS, 8'h00);
        wb(1'b1, IDX_CONTROL, 8'h00);
        peer_u.send(8'h44, 1'b1);
        rd(IDX_FLAGS, 8'h84);
        rd(IDX_RX_BYTE, 8'h11);
        // Non-internal clock source: generator stalls, byte stays put
        wb(1'b1, IDX_CONTROL, 8'h23);
        wb(1'b1, IDX_TX_BYTE, 8'h5A);
        repeat (64) @(posedge clk_i);
        rd(IDX_FLAGS, 8'h00);
        check({7'h0, txd_o}, 8'h01);
        print_verdict();
    end
endmodule : async_serial_port_8n1_bench
`default_nettype wire
